/* File: dpsem_pkg.sv */
package dpsem_pkg;
  localparam int CLK_PERIOD_NS = 4;
  localparam int ADDR_W = 14;
  localparam int DATA_W = 16;
  localparam int SEM_ADDR_W = 3;
  // Times in ns, worst speed grade
  localparam int T_ACCESS_NS = 20;
  localparam int T_BUSY_SETTLE_NS = 20;
  localparam int T_WRITE_HOLD_NS = 15;
  localparam int T_PULSE_NS = 15;
  localparam int T_FLAG_UPDATE_NS = 10;
  localparam int T_FLAG_READ_NS = 5;
  localparam int T_RECOVER_NS = 20;
  // Least times round up to whole cycles; access time gets one cycle more
  localparam logic [3:0] ACCESS_CYC = 4'((T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1);
  localparam logic [3:0] SETTLE_CYC = 4'((T_BUSY_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] WHOLD_CYC = 4'((T_WRITE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] PULSE_CYC = 4'((T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] UPDATE_CYC = 4'((T_FLAG_UPDATE_NS + T_FLAG_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] RECOVER_CYC = 4'((T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [ADDR_W-1:0] MBOX_RIGHT_ADDR = 14'h3fff;
  localparam logic [ADDR_W-1:0] MBOX_LEFT_ADDR = 14'h3ffe;
  localparam int FLAG_BIT = 0;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_SETTLE = 3'b010,
    ST_STROBE = 3'b011,
    ST_WAIT_BUSY = 3'b100,
    ST_FINISH = 3'b101,
    ST_RECOVER = 3'b110
  } dpsem_state_t;
endpackage

/* File: dpsem_host.sv */
// Operation
// - Hold write strobe low after busy high
// - Deselect 10 ns before semaphore read-back
// - Keep chip select high during retention
// - Strobe stays high for every read
// - Memory access: select low, flag select high
// - Strobe high whenever address changes
// - Long write pulse when output enable low
// - Never drive data while device drives
// - Address valid before chip select falls
// - Chip select high through semaphore cycles
`timescale 1ns/1ns
module dpsem_host
  import dpsem_pkg::*;
(
  input wire logic mclk_i,                        // 250 MHz clock
  input wire logic rst_i,                         // Async reset, active high
  input wire logic req_i,                         // Start a transfer, level, taken in idle
  input wire logic req_write_i,                   // 1 write, 0 read
  input wire logic req_flag_i,                    // 1 semaphore access, 0 memory
  input wire logic [ADDR_W-1:0] req_addr_i,       // Word or semaphore address
  input wire logic [DATA_W-1:0] req_wdata_i,      // Write data
  input wire logic [1:0] req_lanes_i,             // Bit1 upper lane, bit0 lower lane
  input wire logic retain_i,                      // Hold the part in retention
  output logic ack_o,                             // One-cycle pulse, transfer done
  output logic [DATA_W-1:0] rdata_o,              // Read data, valid with ack_o
  output logic idle_o,                            // Ready for a request
  output logic [ADDR_W-1:0] addr_o,               // Address pins
  output logic chip_sel_n_o,                      // Memory chip select
  output logic flag_latch_select_n_o,             // Semaphore select
  output logic rw_o,                              // Read high, write low
  output logic oe_n_o,                            // Output enable
  output logic upper_lane_select_n_o,             // Upper byte lane
  output logic lower_lane_select_n_o,             // Lower byte lane
  output logic [DATA_W-1:0] data_o,               // Data pins out
  output logic data_oe_o,                         // High while host drives data
  input wire logic [DATA_W-1:0] data_i,           // Data pins in
  input wire logic busy_n_i                       // Busy pin from device
);
  dpsem_state_t state_ff, nxt_state;
  logic [3:0] cnt_ff, nxt_cnt;
  logic wr_ff, nxt_wr, flag_ff, nxt_flag;
  logic ack_ff, nxt_ack, idle_ff, nxt_idle;
  logic [DATA_W-1:0] rdata_ff, nxt_rdata, wdata_ff, nxt_wdata;
  logic [ADDR_W-1:0] addr_ff, nxt_addr;
  logic cs_n_ff, nxt_cs_n, sem_n_ff, nxt_sem_n, rw_ff, nxt_rw, oe_n_ff, nxt_oe_n;
  logic ub_n_ff, nxt_ub_n, lb_n_ff, nxt_lb_n, doe_ff, nxt_doe;
  logic [2:0] busy_sync_ff, retain_sync_ff;
  logic busy_n_s, retain_s, busy_n_q, retain_q;

  // Three-stage pin synchronisers; a change counts once stages two and three agree
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_sync_ff <= 3'h7;
      retain_sync_ff <= 3'h0;
      busy_n_q <= 1'b1;
      retain_q <= 1'b0;
    end else begin
      busy_sync_ff <= {busy_sync_ff[1:0], busy_n_i};
      retain_sync_ff <= {retain_sync_ff[1:0], retain_i};
      busy_n_q <= busy_n_s;
      retain_q <= retain_s;
    end
  end
  assign busy_n_s = (busy_sync_ff[1] == busy_sync_ff[2]) ? busy_sync_ff[2] : busy_n_q;
  assign retain_s = (retain_sync_ff[1] == retain_sync_ff[2]) ? retain_sync_ff[2] : retain_q;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_wr = wr_ff;
    nxt_flag = flag_ff;
    nxt_ack = 1'b0;
    nxt_idle = idle_ff;
    nxt_rdata = rdata_ff;
    nxt_wdata = wdata_ff;
    nxt_addr = addr_ff;
    nxt_cs_n = cs_n_ff;
    nxt_sem_n = sem_n_ff;
    nxt_rw = rw_ff;
    nxt_oe_n = oe_n_ff;
    nxt_ub_n = ub_n_ff;
    nxt_lb_n = lb_n_ff;
    nxt_doe = doe_ff;
    unique case (state_ff)
      ST_IDLE: begin
        // Address moves only with strobe high and both selects high
        nxt_rw = 1'b1;
        nxt_cs_n = 1'b1;
        nxt_sem_n = 1'b1;
        nxt_idle = !retain_s;
        if (req_i && !retain_s) begin
          nxt_wr = req_write_i;
          nxt_flag = req_flag_i;
          nxt_addr = req_flag_i ? {{(ADDR_W-SEM_ADDR_W){1'b0}}, req_addr_i[SEM_ADDR_W-1:0]} : req_addr_i;
          nxt_wdata = req_flag_i ? {{(DATA_W-1){1'b0}}, req_wdata_i[FLAG_BIT]} : req_wdata_i;
          nxt_ub_n = !req_lanes_i[1];
          nxt_lb_n = !req_lanes_i[0];
          nxt_oe_n = 1'b1;
          nxt_idle = 1'b0;
          nxt_state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        // Address already stable when select falls
        nxt_cs_n = flag_ff;
        nxt_sem_n = !flag_ff;
        nxt_oe_n = wr_ff;
        nxt_cnt = SETTLE_CYC;
        nxt_state = wr_ff ? ST_SETTLE : ST_STROBE;
      end
      ST_SETTLE: begin
        // Let slave busy settle before the strobe falls
        if (cnt_ff != 4'h0) begin
          nxt_cnt = cnt_ff - 4'h1;
        end else begin
          nxt_rw = 1'b0;
          nxt_doe = 1'b1;
          nxt_cnt = PULSE_CYC;
          nxt_state = ST_STROBE;
        end
      end
      ST_STROBE: begin
        if (!wr_ff && cnt_ff == 4'h0) begin
          nxt_cnt = ACCESS_CYC;
        end
        if (cnt_ff != 4'h0) begin
          nxt_cnt = cnt_ff - 4'h1;
        end else if (!busy_n_s && !flag_ff) begin
          nxt_state = ST_WAIT_BUSY;
        end else begin
          nxt_state = ST_FINISH;
          nxt_cnt = wr_ff ? 4'h0 : ACCESS_CYC;
        end
      end
      ST_WAIT_BUSY: begin
        // Lost arbitration: hold strobe and selects as they are (strobe low on writes) until busy clears
        if (busy_n_s) begin
          nxt_cnt = wr_ff ? WHOLD_CYC : ACCESS_CYC;
          nxt_state = ST_FINISH;
        end
      end
      ST_FINISH: begin
        if (cnt_ff != 4'h0) begin
          nxt_cnt = cnt_ff - 4'h1;
        end else begin
          if (!wr_ff) begin
            nxt_rdata = flag_ff ? {{(DATA_W-1){1'b0}}, data_i[FLAG_BIT]} : data_i;
          end
          nxt_rw = 1'b1;
          nxt_cs_n = 1'b1;
          nxt_sem_n = 1'b1;
          nxt_oe_n = 1'b1;
          nxt_cnt = flag_ff ? UPDATE_CYC : RECOVER_CYC;
          nxt_ack = 1'b1;
          nxt_state = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        nxt_doe = 1'b0;
        if (cnt_ff != 4'h0) begin
          nxt_cnt = cnt_ff - 4'h1;
        end else begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
      wr_ff <= 1'b0;
      flag_ff <= 1'b0;
      ack_ff <= 1'b0;
      idle_ff <= 1'b0;
      rdata_ff <= 16'h0000;
      wdata_ff <= 16'h0000;
      addr_ff <= 14'h0000;
      cs_n_ff <= 1'b1;
      sem_n_ff <= 1'b1;
      rw_ff <= 1'b1;
      oe_n_ff <= 1'b1;
      ub_n_ff <= 1'b1;
      lb_n_ff <= 1'b1;
      doe_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      wr_ff <= nxt_wr;
      flag_ff <= nxt_flag;
      ack_ff <= nxt_ack;
      idle_ff <= nxt_idle;
      rdata_ff <= nxt_rdata;
      wdata_ff <= nxt_wdata;
      addr_ff <= nxt_addr;
      cs_n_ff <= nxt_cs_n;
      sem_n_ff <= nxt_sem_n;
      rw_ff <= nxt_rw;
      oe_n_ff <= nxt_oe_n;
      ub_n_ff <= nxt_ub_n;
      lb_n_ff <= nxt_lb_n;
      doe_ff <= nxt_doe;
    end
  end

  assign ack_o = ack_ff;
  assign rdata_o = rdata_ff;
  assign idle_o = idle_ff;
  assign addr_o = addr_ff;
  assign chip_sel_n_o = cs_n_ff;
  assign flag_latch_select_n_o = sem_n_ff;
  assign rw_o = rw_ff;
  assign oe_n_o = oe_n_ff;
  assign upper_lane_select_n_o = ub_n_ff;
  assign lower_lane_select_n_o = lb_n_ff;
  assign data_o = wdata_ff;
  assign data_oe_o = doe_ff;
endmodule

/* File: dpsem_host_sva.sv */
`timescale 1ns/1ns
module dpsem_host_sva
  import dpsem_pkg::*;
(
  input wire logic mclk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic req_i, // Request
  input wire logic retain_i, // Retention
  input wire logic ack_o, // Done
  input wire logic [ADDR_W-1:0] addr_o, // Address
  input wire logic chip_sel_n_o, // Memory select
  input wire logic flag_latch_select_n_o, // Flag select
  input wire logic rw_o, // Strobe
  input wire logic oe_n_o, // Output enable
  input wire logic upper_lane_select_n_o, // Upper lane
  input wire logic lower_lane_select_n_o, // Lower lane
  input wire logic data_oe_o, // Host drives data
  input wire logic busy_n_i // Busy
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  a_retain_deselect: assert property ((retain_i && !req_i) [*4] |-> chip_sel_n_o)
    else $error("select during retention");
  a_no_bus_fight: assert property (data_oe_o |-> oe_n_o)
    else $error("host drives while output enabled");
  a_addr_strobe_high: assert property ($changed(addr_o) |-> rw_o && $past(rw_o))
    else $error("address moved with strobe low");
  a_memory_select_form: assert property (!chip_sel_n_o |-> flag_latch_select_n_o &&
    !(upper_lane_select_n_o && lower_lane_select_n_o)) else $error("bad memory select");
  a_flag_select_form: assert property (!flag_latch_select_n_o |-> chip_sel_n_o)
    else $error("memory selected in flag access");
  a_addr_before_select: assert property ($fell(chip_sel_n_o) |-> $stable(addr_o))
    else $error("address not settled at select");
  a_busy_write_hold: assert property (!rw_o && !chip_sel_n_o && $rose(busy_n_i) |-> !rw_o [*4])
    else $error("strobe released early after busy");
  a_pulse_width: assert property ($fell(rw_o) |-> !rw_o [*4])
    else $error("write pulse too short");
  c_busy_write: cover property (!rw_o && $rose(busy_n_i));
  c_flag_access: cover property ($fell(flag_latch_select_n_o));
  c_retention: cover property (retain_i [*4]);
endmodule
bind dpsem_host dpsem_host_sva chk_u (.mclk_i, .rst_i, .req_i, .retain_i, .ack_o, .addr_o, .chip_sel_n_o,
  .flag_latch_select_n_o, .rw_o, .oe_n_o, .upper_lane_select_n_o, .lower_lane_select_n_o, .data_oe_o, .busy_n_i);

/* File: dpsem_dev.sv */
`timescale 1ns/1ns
module dpsem_dev
  import dpsem_pkg::*;
(
  input wire logic clk_i, // Clock for busy timing
  input wire logic [ADDR_W-1:0] addr_i, // Address
  input wire logic chip_sel_n_i, // Memory select
  input wire logic flag_sel_n_i, // Flag select
  input wire logic rw_i, // Strobe
  input wire logic oe_n_i, // Output enable
  input wire logic [1:0] lanes_n_i, // Upper, lower lane
  input wire logic [DATA_W-1:0] data_i, // Data from host
  input wire logic contend_i, // Other port on this word
  input wire logic [31:0] hold_i, // Cycles the other port stays
  input wire logic [7:0] other_own_i, // Flags held by other port
  output logic [DATA_W-1:0] data_o, // Data to host
  output logic busy_n_o // Busy to host
);
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [7:0] own = 8'h00;
  logic [DATA_W-1:0] last = '0;
  wire drv = !oe_n_i && rw_i && busy_n_o && (!chip_sel_n_i || !flag_sel_n_i);
  wire [DATA_W-1:0] val = !flag_sel_n_i ? {DATA_W{!own[addr_i[2:0]]}} : mem[addr_i];
  // Undriven pins show the inverse of the last value
  assign data_o = drv ? val : ~last;
  initial busy_n_o = 1'b1;
  always @(posedge clk_i) if (drv) last <= val;
  // Slave part: write lands on each clock of the select, lane and strobe overlap; low busy blocks it
  always @(posedge clk_i) begin
    if (!rw_i && !chip_sel_n_i && busy_n_o) begin
      if (!lanes_n_i[1]) mem[addr_i][15:8] <= data_i[15:8];
      if (!lanes_n_i[0]) mem[addr_i][7:0] <= data_i[7:0];
    end else if (!rw_i && !flag_sel_n_i) own[addr_i[2:0]] <= !data_i[FLAG_BIT] && !other_own_i[addr_i[2:0]];
  end
  // The other port wins when contend_i is set at select time
  always @(negedge chip_sel_n_i) if (contend_i) begin
    busy_n_o <= 1'b0;
    repeat (hold_i) @(posedge clk_i);
    busy_n_o <= 1'b1;
  end
endmodule

/* File: tb.sv */
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fails++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb;
  import dpsem_pkg::*;
  logic mclk_i = 0, rst_i = 1, req_i = 0, req_write_i = 0, req_flag_i = 0, retain_i = 0, contend = 0;
  logic [ADDR_W-1:0] req_addr_i = '0, addr_o, a;
  logic [DATA_W-1:0] req_wdata_i = '0, rdata_o, host_q, dev_q, d, q;
  logic [DATA_W-1:0] mirror [8];
  logic [1:0] req_lanes_i = 2'b11, l;
  logic [7:0] other = 8'h00;
  logic ack_o, idle_o, chip_sel_n_o, flag_latch_select_n_o, rw_o, oe_n_o, data_oe_o, busy_n_i, oth;
  logic upper_lane_select_n_o, lower_lane_select_n_o;
  int hold = 14, fails = 0, tests_run = 0;
  wire [DATA_W-1:0] bus = data_oe_o ? host_q : dev_q;
  dpsem_host dut_u (.mclk_i, .rst_i, .req_i, .req_write_i, .req_flag_i, .req_addr_i, .req_wdata_i, .req_lanes_i,
    .retain_i, .ack_o, .rdata_o, .idle_o, .addr_o, .chip_sel_n_o, .flag_latch_select_n_o, .rw_o, .oe_n_o,
    .upper_lane_select_n_o, .lower_lane_select_n_o, .data_o(host_q), .data_oe_o, .data_i(bus), .busy_n_i);
  dpsem_dev dev_u (.clk_i(mclk_i), .addr_i(addr_o), .chip_sel_n_i(chip_sel_n_o), .flag_sel_n_i(flag_latch_select_n_o),
    .rw_i(rw_o), .oe_n_i(oe_n_o), .lanes_n_i({upper_lane_select_n_o, lower_lane_select_n_o}), .data_i(bus),
    .contend_i(contend), .hold_i(hold), .other_own_i(other), .data_o(dev_q), .busy_n_o(busy_n_i));
  always #2 mclk_i = ~mclk_i;
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o, n, input logic [1:0] m);
    return {m[1] ? n[15:8] : o[15:8], m[0] ? n[7:0] : o[7:0]};
  endfunction
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Wait for idle, present the request for the one edge that takes it; waits are bounded
  task automatic op(input logic w, f, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] wd,
                    input logic [1:0] ln, output logic [DATA_W-1:0] rd);
    int n;
    n = 0;
    while (idle_o !== 1'b1 && n < 100) begin
      @(posedge mclk_i);
      n++;
    end
    {req_i, req_write_i, req_flag_i, req_addr_i, req_wdata_i, req_lanes_i} <= {1'b1, w, f, ad, wd, ln};
    @(posedge mclk_i);
    req_i <= 1'b0;
    do @(posedge mclk_i); while (ack_o !== 1'b1 && ++n < 400);
    rd = rdata_o;
    if (ack_o !== 1'b1) begin
      fails++;
      $display("[FAIL] %0t no ack", $time);
    end
  endtask
  initial begin
    void'($urandom(58868));
    repeat (6) @(posedge mclk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 30; i++) begin
      a = 14'h3ff8 + 14'(i < 8 ? i : $urandom_range(7));
      l = i < 8 ? 2'b11 : 2'($urandom_range(3, 1));
      d = 16'($urandom);
      contend <= 1'($urandom);
      hold <= $urandom_range(24, 14);
      op(1'b1, 1'b0, a, d, l, q);
      mirror[a[2:0]] = merge(mirror[a[2:0]], d, l);
      contend <= 1'($urandom);
      op(1'b0, 1'b0, a, '0, 2'b11, q);
      `CHK(q, mirror[a[2:0]])
    end
    $display("memory test done");
    contend <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      oth = i > 0 && 1'($urandom);
      other <= {7'h00, oth} << i;
      op(1'b1, 1'b1, {11'($urandom), 3'(i)}, 16'hfffe, 2'b11, q);
      op(1'b0, 1'b1, {11'($urandom), 3'(i)}, '0, 2'b11, q);
      `CHK(q[0], oth)
      op(1'b1, 1'b1, {11'h000, 3'(i)}, 16'h0001, 2'b11, q);
      op(1'b0, 1'b1, {11'h000, 3'(i)}, '0, 2'b11, q);
      `CHK(q[0], 1'b1)
    end
    $display("semaphore test done");
    retain_i <= 1'b1;
    repeat (6) @(posedge mclk_i);
    {req_i, req_write_i, req_flag_i, req_addr_i, req_lanes_i} <= {1'b1, 1'b0, 1'b0, 14'h3ffe, 2'b11};
    repeat (20) begin
      @(posedge mclk_i);
      `CHK(ack_o, 1'b0)
      `CHK(chip_sel_n_o, 1'b1)
    end
    {req_i, retain_i} <= 2'b00;
    op(1'b0, 1'b0, 14'h3ffe, '0, 2'b11, q);
    `CHK(q, mirror[6])
    $display("retention test done");
    conclude();
  end
  initial begin
    #200000;
    fails++;
    conclude();
  end
endmodule
